// *** pkg/tieu_regs.vh ***
// Constants for the technology event interrupt unit: modes, event word layout,
// diagnostic record layout and queue sizing. Definitions only.
`ifndef TIEU_REGS_VH
`define TIEU_REGS_VH

// ----------------------------------------------------------------------------
// Technology function select
// ----------------------------------------------------------------------------
`define TIEU_MODE_NONE      2'h0
`define TIEU_MODE_COUNT     2'h1
`define TIEU_MODE_FREQ      2'h2
`define TIEU_MODE_PWM       2'h3

// ----------------------------------------------------------------------------
// Event word: byte positions (bytes 8..11 of the handler's local data)
// ----------------------------------------------------------------------------
`define TIEU_EV_IN0_LSB     0
`define TIEU_EV_IN1_LSB     8
`define TIEU_EV_CNT01_LSB   16
`define TIEU_EV_CNT2_LSB    24
`define TIEU_EV_FREQ0_BIT   16
`define TIEU_EV_FREQ1_BIT   20
`define TIEU_EV_FREQ2_BIT   24

// ----------------------------------------------------------------------------
// Diagnostic record offsets
// ----------------------------------------------------------------------------
`define TIEU_DIAG_ERROR_SUMMARY   2'h0
`define TIEU_DIAG_MODULE_CLASS    2'h1
`define TIEU_DIAG_FIXED_ZERO      2'h2
`define TIEU_DIAG_LOST_INTERRUPT  2'h3

// ----------------------------------------------------------------------------
// Diagnostic record fields
// ----------------------------------------------------------------------------
`define TIEU_B0_MODULE_FAIL 0
`define TIEU_B0_EXT_ERR     2
`define TIEU_B0_CHAN_ERR    3
`define TIEU_B1_CHAN_INFO   4
`define TIEU_B3_LOST        6
`define TIEU_CLASS_ANALOG   4'h5
`define TIEU_CLASS_DIGITAL  4'hf
`define TIEU_REC_RESET      8'h00

// ----------------------------------------------------------------------------
// Diagnostic queue sizing
// ----------------------------------------------------------------------------
`define TIEU_DQ_DEPTH       8
`define TIEU_DQ_AW          3

`endif

// *** rtl/tieu_event_map.v ***
// Maps raw technology events into the 32-bit process event word.
// Assumes single-cycle event pulses synchronous to the module clock.
`timescale 1ns/10ps
`include "tieu_regs.vh"

module tieu_event_map (
  // Mode
  input  wire [1:0]  mode_i,
  // Raw events
  input  wire [15:0] edge_i,
  input  wire [2:0]  gate_open_i,
  input  wire [2:0]  gate_close_i,
  input  wire [2:0]  software_gate_i,
  input  wire [2:0]  ovf_i,
  input  wire [2:0]  unf_i,
  input  wire [2:0]  end_val_i,
  input  wire [2:0]  cmp_i,
  input  wire [2:0]  meas_end_i,
  // Event word
  output reg  [31:0] ev_o
);

  // ------------------------------------------------------------------------
  // Event word assembly
  // ------------------------------------------------------------------------
  // Reserved bits stay zero in every mode
  reg [3:0] cnt_ev [0:2];
  integer   k;
  always @* begin
    ev_o = 32'h0000_0000;
    for (k = 0; k < 3; k = k + 1) begin
      cnt_ev[k] = {cmp_i[k],
                   ovf_i[k] | unf_i[k] | end_val_i[k],
                   gate_close_i[k] & software_gate_i[k],
                   gate_open_i[k] & software_gate_i[k]};
    end
    case (mode_i)
      `TIEU_MODE_COUNT: begin
        ev_o[15:0]  = edge_i;
        ev_o[23:16] = {cnt_ev[1], cnt_ev[0]};
        ev_o[27:24] = cnt_ev[2];
      end
      `TIEU_MODE_FREQ: begin
        ev_o[15:0] = edge_i;
        ev_o[`TIEU_EV_FREQ0_BIT] = meas_end_i[0];
        ev_o[`TIEU_EV_FREQ1_BIT] = meas_end_i[1];
        ev_o[`TIEU_EV_FREQ2_BIT] = meas_end_i[2];
      end
      default: begin
        ev_o = 32'h0000_0000;
      end
    endcase
  end

endmodule // tieu_event_map

// *** rtl/tieu_diag_queue.v ***
// Ordered queue of pending diagnostic interrupts (incoming/outgoing + channel).
// Assumes the writer holds its entry while full is high.
`timescale 1ns/10ps
`include "tieu_regs.vh"

module tieu_diag_queue #(
  parameter W     = 6,
  parameter DEPTH = `TIEU_DQ_DEPTH,
  parameter AW    = `TIEU_DQ_AW
) (
  // Clock and reset
  input  wire         clk_i,
  input  wire         rst_n_i,
  // Write side
  input  wire         push_i,
  input  wire [W-1:0] data_i,
  output wire         full_o,
  // Read side
  input  wire         pop_i,
  output wire [W-1:0] data_o,
  output wire         empty_o
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW:0]  wr_q;
  reg [AW:0]  rd_q;

  assign empty_o = (wr_q == rd_q);
  assign full_o  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign data_o  = mem[rd_q[AW-1:0]];

  // ------------------------------------------------------------------------
  // Pointers
  // ------------------------------------------------------------------------
  // Extra pointer bit tells full from empty
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push_i && !full_o) begin
        wr_q <= wr_q + {{AW{1'b0}}, 1'b1};
      end
      if (pop_i && !empty_o) begin
        rd_q <= rd_q + {{AW{1'b0}}, 1'b1};
      end
    end
  end

  // Storage has no reset; only read where the pointers say valid
  always @(posedge clk_i) begin
    if (push_i && !full_o) begin
      mem[wr_q[AW-1:0]] <= data_i;
    end
  end

endmodule // tieu_diag_queue

// *** rtl/tieu_top.v ***
// Technology event interrupt unit: process interrupts, diagnostic escalation,
// fault indicator and diagnostic record.
// Assumes events, configuration and handler acknowledges are synchronous to CLK_I.
//
// Notes on behaviour
// - Process interrupts only with counter output enabled and diagnostics+process set.
// - Pulse width modulation channels never produce process interrupts.
// - Bytes 8 and 9 flag edges on inputs 0.0-0.7 and 1.0-1.7.
// - Counter byte 10: gate open, close, over/underflow/end, compare for counters 0,1.
// - Counter byte 11: same four events for counter 2, upper nibble reserved.
// - Frequency byte 10: integration end channel 0 bit 0, channel 1 bit 4.
// - Frequency byte 11: integration end channel 2 in bit 0.
// - Hardware gate edges trigger only while the software gate is open.
// - Overflow and underflow of the count are selectable triggers.
// - Diagnostics need a technology function and diagnostics+process setting.
// - One module-wide diagnostic interrupt enable from configuration record 7Fh.
// - Repeat of an event still being handled raises incoming diagnostic.
// - Incoming diagnostic preempts process handling in progress.
// - During diagnostic handling, other channel events are held back.
// - After diagnostics: queued diagnostics in order first, then process events.
// - Events on a channel under diagnosis are discarded until outgoing.
// - When the causing process interrupt completes, outgoing diagnostic follows.
// - Fault indicator spans first incoming to last outgoing; each logged once.
// - Record byte 0: module failure, external error, channel error bits.
// - Record byte 1: module class low nibble, channel info flag bit 4.
// - Record byte 2 is zero; byte 3 bit 6 marks a lost process interrupt.
// - With diagnostics disabled the latest diagnostic event stays readable.
// - Outgoing diagnostic is issued only while the enable is still active.
`timescale 1ns/10ps
`include "tieu_regs.vh"

module tieu_top #(
  parameter ADDR_W    = 16,
  parameter DQ_DEPTH  = `TIEU_DQ_DEPTH,
  parameter DQ_AW     = `TIEU_DQ_AW
) (
  // Clock and reset
  input  wire              CLK_I,
  input  wire              RSTN_I,
  // Configuration
  input  wire [1:0]        MODE_I,
  input  wire              DIAG_PROC_SEL_I,
  input  wire              CNT_OUT_EN_I,
  input  wire              DIAG_IRQ_EN_I,
  input  wire [31:0]       TRIG_EN_I,
  input  wire [ADDR_W-1:0] MODULE_BASE_I,
  input  wire              CLASS_DIGITAL_I,
  // Technology events
  input  wire [15:0]       EDGE_I,
  input  wire [2:0]        GATE_OPEN_I,
  input  wire [2:0]        GATE_CLOSE_I,
  input  wire [2:0]        SOFTWARE_GATE_I,
  input  wire [2:0]        OVF_I,
  input  wire [2:0]        UNF_I,
  input  wire [2:0]        END_VAL_I,
  input  wire [2:0]        CMP_I,
  input  wire [2:0]        MEAS_END_I,
  // Error conditions for the diagnostic record
  input  wire              MODULE_FAIL_I,
  input  wire              EXT_ERR_I,
  // Process interrupt to the host
  output reg               PROC_IRQ_O,
  output reg  [31:0]       PROC_INFO_O,
  output reg  [ADDR_W-1:0] PROC_ADDR_O,
  input  wire              PROC_ACK_I,
  // Diagnostic interrupt to the host
  output reg               DIAG_IRQ_O,
  output reg               DIAG_INCOMING_O,
  output reg  [4:0]        DIAG_CHAN_O,
  input  wire              DIAG_ACK_I,
  output reg               DIAG_LOG_O,
  output reg               FAULT_O,
  // Diagnostic record read port
  input  wire [1:0]        REC_ADDR_I,
  output reg  [7:0]        REC_DATA_O
);

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  reg rst_meta_q;
  reg rst_n_q;
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Lowest set bit, as one-hot
  function [31:0] low_one;
    input [31:0] v;
    begin
      low_one = v & (~v + 32'h0000_0001);
    end
  endfunction

  // Index of a one-hot vector
  function [4:0] one_idx;
    input [31:0] v;
    integer i;
    begin
      one_idx = 5'h00;
      for (i = 0; i < 32; i = i + 1) begin
        if (v[i]) begin
          one_idx = i[4:0];
        end
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Event word and enables
  // --------------------------------------------------------------------------
  wire [31:0] ev;
  tieu_event_map u_map (
    .mode_i       (MODE_I),
    .edge_i       (EDGE_I),
    .gate_open_i  (GATE_OPEN_I),
    .gate_close_i (GATE_CLOSE_I),
    .software_gate_i    (SOFTWARE_GATE_I),
    .ovf_i        (OVF_I),
    .unf_i        (UNF_I),
    .end_val_i    (END_VAL_I),
    .cmp_i        (CMP_I),
    .meas_end_i   (MEAS_END_I),
    .ev_o         (ev)
  );

  wire proc_ok = CNT_OUT_EN_I && DIAG_PROC_SEL_I;
  wire diag_on = DIAG_PROC_SEL_I && (MODE_I != `TIEU_MODE_NONE);
  wire diag_ok = diag_on && DIAG_IRQ_EN_I;
  wire [31:0] trig = ev & TRIG_EN_I & {32{proc_ok}};

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg  [31:0] pend_q;      // Process events waiting for delivery
  reg  [31:0] info_q;      // Event word of the interrupt in service
  reg         proc_act_q;  // Process interrupt outstanding
  reg  [31:0] dch_q;       // Channels between incoming and outgoing
  reg  [31:0] cause_q;     // Channels whose cause is still in service
  reg  [31:0] in_pend_q;   // Incoming entries not yet queued
  reg  [31:0] out_pend_q;  // Outgoing entries not yet queued
  reg         diag_act_q;  // Diagnostic interrupt outstanding
  reg         dent_in_q;   // Entry in service is incoming
  reg  [4:0]  dent_ch_q;   // Channel of the entry in service
  reg  [7:0]  rec0_q;
  reg  [7:0]  rec1_q;
  reg  [7:0]  rec3_q;

  // --------------------------------------------------------------------------
  // Repeat detection and discard
  // --------------------------------------------------------------------------
  // A repeat is an event that fires again while its own interrupt is in service
  wire [31:0] live   = trig & ~dch_q & ~in_pend_q;
  wire [31:0] repeat_ev = live & info_q & {32{proc_act_q}};
  wire [31:0] esc    = repeat_ev & {32{diag_ok}};
  // Without escalation the repeat simply waits as a normal pending event
  wire [31:0] to_pend = live & ~esc;

  // --------------------------------------------------------------------------
  // Diagnostic queue
  // --------------------------------------------------------------------------
  wire [31:0] in_pick  = low_one(in_pend_q);
  wire [31:0] out_pick = low_one(out_pend_q);
  wire        dq_full;
  wire        dq_empty;
  wire [5:0]  dq_dout;
  // Incoming entries go first; the queue keeps their order of arrival
  wire        push_in  = |in_pend_q;
  wire        push_out = !push_in && |out_pend_q;
  wire        dq_push  = (push_in || push_out) && !dq_full;
  wire [5:0]  dq_din   = push_in ? {1'b1, one_idx(in_pick)} : {1'b0, one_idx(out_pick)};
  wire        dq_pop   = !diag_act_q && !dq_empty;

  tieu_diag_queue #(
    .W     (6),
    .DEPTH (DQ_DEPTH),
    .AW    (DQ_AW)
  ) u_dq (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n_q),
    .push_i  (dq_push),
    .data_i  (dq_din),
    .full_o  (dq_full),
    .pop_i   (dq_pop),
    .data_o  (dq_dout),
    .empty_o (dq_empty)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  reg  [31:0] pend_d;
  reg  [31:0] info_d;
  reg         proc_act_d;
  reg  [31:0] dch_d;
  reg  [31:0] cause_d;
  reg  [31:0] in_pend_d;
  reg  [31:0] out_pend_d;
  reg         diag_act_d;
  reg         dent_in_d;
  reg  [4:0]  dent_ch_d;
  reg  [31:0] done_ch;
  reg  [31:0] dent_oh;

  always @* begin
    pend_d     = pend_q;
    info_d     = info_q;
    proc_act_d = proc_act_q;
    dch_d      = dch_q;
    cause_d    = cause_q;
    in_pend_d  = in_pend_q;
    out_pend_d = out_pend_q;
    diag_act_d = diag_act_q;
    dent_in_d  = dent_in_q;
    dent_ch_d  = dent_ch_q;
    done_ch    = 32'h0000_0000;
    dent_oh    = 32'h0000_0001 << dent_ch_q;

    // Acknowledge of the process handler closes the causing interrupt
    if (proc_act_q && PROC_ACK_I) begin
      proc_act_d = 1'b0;
      done_ch    = cause_q | (esc & info_q);
      out_pend_d = out_pend_d | (done_ch & {32{diag_ok}});
      cause_d    = cause_q & ~done_ch;
      // Enable dropped: the channel recovers silently
      dch_d      = dch_d & ~(done_ch & {32{~diag_ok}});
    end
    // Escalated channels start the discard window
    in_pend_d = in_pend_d | esc;
    dch_d     = dch_d | esc;
    if (!(proc_act_q && PROC_ACK_I)) begin
      cause_d = cause_d | esc;
    end

    // Move one pending entry into the ordered queue
    if (dq_push && push_in) begin
      in_pend_d = in_pend_d & ~in_pick;
    end
    if (dq_push && push_out) begin
      out_pend_d = out_pend_d & ~out_pick;
    end

    // Diagnostic service
    if (diag_act_q && DIAG_ACK_I) begin
      diag_act_d = 1'b0;
      if (!dent_in_q) begin
        dch_d = dch_d & ~dent_oh;
      end
    end
    if (dq_pop) begin
      diag_act_d = 1'b1;
      dent_in_d  = dq_dout[5];
      dent_ch_d  = dq_dout[4:0];
    end

    // Process events: new ones in the same cycle as the take stay pending
    if (!proc_act_d && !diag_act_d && dq_empty && !push_in && |pend_q) begin
      info_d     = pend_q;
      proc_act_d = 1'b1;
      pend_d     = to_pend;
    end else begin
      pend_d     = pend_q | to_pend;
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pend_q     <= 32'h0000_0000;
      info_q     <= 32'h0000_0000;
      proc_act_q <= 1'b0;
      dch_q      <= 32'h0000_0000;
      cause_q    <= 32'h0000_0000;
      in_pend_q  <= 32'h0000_0000;
      out_pend_q <= 32'h0000_0000;
      diag_act_q <= 1'b0;
      dent_in_q  <= 1'b0;
      dent_ch_q  <= 5'h00;
    end else begin
      pend_q     <= pend_d;
      info_q     <= info_d;
      proc_act_q <= proc_act_d;
      dch_q      <= dch_d;
      cause_q    <= cause_d;
      in_pend_q  <= in_pend_d;
      out_pend_q <= out_pend_d;
      diag_act_q <= diag_act_d;
      dent_in_q  <= dent_in_d;
      dent_ch_q  <= dent_ch_d;
    end
  end

  // --------------------------------------------------------------------------
  // Host outputs
  // --------------------------------------------------------------------------
  // Diagnostic service masks the process line, so the host branches away
  always @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      PROC_IRQ_O      <= 1'b0;
      PROC_INFO_O     <= 32'h0000_0000;
      PROC_ADDR_O     <= {ADDR_W{1'b0}};
      DIAG_IRQ_O      <= 1'b0;
      DIAG_INCOMING_O <= 1'b0;
      DIAG_CHAN_O     <= 5'h00;
      DIAG_LOG_O      <= 1'b0;
      FAULT_O         <= 1'b0;
    end else begin
      PROC_IRQ_O      <= proc_act_d && !diag_act_d;
      PROC_INFO_O     <= proc_act_d ? info_d : 32'h0000_0000;
      PROC_ADDR_O     <= proc_act_d ? MODULE_BASE_I : {ADDR_W{1'b0}};
      DIAG_IRQ_O      <= diag_act_d;
      DIAG_INCOMING_O <= diag_act_d && dent_in_d;
      DIAG_CHAN_O     <= diag_act_d ? dent_ch_d : 5'h00;
      DIAG_LOG_O      <= dq_pop;
      // On from the first incoming, off once no channel is under diagnosis
      if (dq_pop && dq_dout[5]) begin
        FAULT_O <= 1'b1;
      end else if (dch_d == 32'h0000_0000 && !diag_act_d) begin
        FAULT_O <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Diagnostic record
  // --------------------------------------------------------------------------
  // Updated on every delivered entry and on every repeat even when disabled,
  // so the latest event stays readable
  wire rec_in  = (dq_pop && dq_dout[5]) || (|repeat_ev && diag_on && !DIAG_IRQ_EN_I);
  wire rec_out = dq_pop && !dq_dout[5];
  wire [3:0] mod_class = CLASS_DIGITAL_I ? `TIEU_CLASS_DIGITAL : `TIEU_CLASS_ANALOG;

  always @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rec0_q     <= `TIEU_REC_RESET;
      rec1_q     <= `TIEU_REC_RESET;
      rec3_q     <= `TIEU_REC_RESET;
      REC_DATA_O <= `TIEU_REC_RESET;
    end else begin
      if (rec_in || rec_out) begin
        rec0_q <= 8'h00;
        rec0_q[`TIEU_B0_MODULE_FAIL] <= MODULE_FAIL_I;
        rec0_q[`TIEU_B0_EXT_ERR]     <= EXT_ERR_I;
        rec0_q[`TIEU_B0_CHAN_ERR]    <= rec_in;
        rec1_q <= {3'h0, rec_in, mod_class};
        rec3_q <= 8'h00;
        rec3_q[`TIEU_B3_LOST]        <= rec_in;
      end
      case (REC_ADDR_I)
        `TIEU_DIAG_ERROR_SUMMARY:  REC_DATA_O <= rec0_q;
        `TIEU_DIAG_MODULE_CLASS:   REC_DATA_O <= rec1_q;
        `TIEU_DIAG_FIXED_ZERO:     REC_DATA_O <= 8'h00;
        `TIEU_DIAG_LOST_INTERRUPT: REC_DATA_O <= rec3_q;
        default:                   REC_DATA_O <= 8'h00;
      endcase
    end
  end

endmodule // tieu_top

// *** verification/tieu_top_chk.sv ***
// Port-level checker for the technology event interrupt unit.
// Assumes one clock and the raw active-low reset of the top module.
`timescale 1ns/10ps
module tieu_top_chk (
  input wire        CLK_I,
  input wire        RSTN_I,
  input wire [1:0]  MODE_I,
  input wire        CNT_OUT_EN_I,
  input wire        PROC_ACK_I,
  input wire        PROC_IRQ_O,
  input wire [31:0] PROC_INFO_O,
  input wire        DIAG_IRQ_O,
  input wire        DIAG_INCOMING_O,
  input wire        DIAG_LOG_O,
  input wire        FAULT_O,
  input wire [1:0]  REC_ADDR_I,
  input wire [7:0]  REC_DATA_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // Three cycles of PWM leave no room for a fresh request
  a_no_pwm_irq: assert property (MODE_I == 2'h3 && $past(MODE_I) == 2'h3 &&
    $past(MODE_I, 2) == 2'h3 |-> !$rose(PROC_IRQ_O)) else $error("irq in pwm mode");
  a_irq_needs_en: assert property ($rose(PROC_IRQ_O) |-> $past(CNT_OUT_EN_I, 2))
    else $error("irq without counter output");
  a_info_with_irq: assert property (PROC_IRQ_O |-> PROC_INFO_O != 32'h0)
    else $error("irq with empty event word");
  a_irq_holds: assert property (PROC_IRQ_O && !PROC_ACK_I && !$past(PROC_ACK_I)
    |=> PROC_IRQ_O || DIAG_IRQ_O) else $error("irq dropped before ack");
  a_preempt_proc: assert property ($rose(DIAG_IRQ_O) && DIAG_INCOMING_O
    |-> !PROC_IRQ_O) else $error("process irq not preempted");
  a_log_per_diag: assert property ($rose(DIAG_IRQ_O) |-> DIAG_LOG_O)
    else $error("diagnostic not logged");
  a_fault_on_in: assert property ($rose(DIAG_IRQ_O) && DIAG_INCOMING_O |-> FAULT_O)
    else $error("fault indicator off");
  a_rec_zero: assert property ($past(REC_ADDR_I) == 2'h2 |-> REC_DATA_O == 8'h00)
    else $error("record byte 2 not zero");
endmodule // tieu_top_chk

// *** verification/tieu_host_model.sv ***
// Host model: ends process and diagnostic handling after a short run time.
// Assumes level requests from the unit; hold_i keeps both handlers busy.
`timescale 1ns/10ps
module tieu_host_model (
  input  wire clk_i,
  input  wire rst_n_i,
  input  wire hold_i,
  input  wire proc_irq_i,
  input  wire diag_irq_i,
  output reg  proc_ack_o,
  output reg  diag_ack_o
);
  reg [2:0] p_cnt_q;
  reg [2:0] d_cnt_q;
  // Run time counts only while a request stands, so a preempted handler restarts
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p_cnt_q    <= 3'h0;
      d_cnt_q    <= 3'h0;
      proc_ack_o <= 1'b0;
      diag_ack_o <= 1'b0;
    end else begin
      p_cnt_q    <= (proc_irq_i && !hold_i && !proc_ack_o) ? p_cnt_q + 3'h1 : 3'h0;
      d_cnt_q    <= (diag_irq_i && !hold_i && !diag_ack_o) ? d_cnt_q + 3'h1 : 3'h0;
      proc_ack_o <= (p_cnt_q == 3'h3);
      diag_ack_o <= (d_cnt_q == 3'h3);
    end
  end
endmodule // tieu_host_model

// *** verification/tieu_top_bench.sv ***
// Self-checking bench for the technology event interrupt unit.
// Assumes the checker and host model are compiled before this file.
`timescale 1ns/10ps
module tieu_top_bench;
  // cfg: hold, ext error, diag enable, counter output, diag+process, mode
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg  [6:0]  cfg = 7'h1d;
  reg  [36:0] ev = 37'h0;
  reg  [2:0]  swg = 3'h7;
  reg  [1:0]  raddr = 2'h0;
  reg         mfail = 1'b0;
  reg         cls = 1'b1;
  wire        p_irq, p_ack, d_irq, d_ack, d_in, fault, dlog;
  wire [31:0] info;
  wire [15:0] paddr;
  wire [4:0]  chan;
  wire [7:0]  rdata;
  integer     fail_count = 0;
  integer     comparisons = 0;
  integer     n;
  initial forever #5 clk = ~clk;
  tieu_top u_dut (.CLK_I(clk), .RSTN_I(rstn), .MODE_I(cfg[1:0]), .DIAG_PROC_SEL_I(cfg[2]),
    .CNT_OUT_EN_I(cfg[3]), .DIAG_IRQ_EN_I(cfg[4]), .TRIG_EN_I(32'hffffffff),
    .MODULE_BASE_I(16'h1234), .CLASS_DIGITAL_I(cls), .EDGE_I(ev[15:0]),
    .GATE_OPEN_I(ev[18:16]), .GATE_CLOSE_I(ev[21:19]), .SOFTWARE_GATE_I(swg), .OVF_I(ev[24:22]),
    .UNF_I(ev[27:25]), .END_VAL_I(ev[30:28]), .CMP_I(ev[33:31]), .MEAS_END_I(ev[36:34]),
    .MODULE_FAIL_I(mfail), .EXT_ERR_I(cfg[5]), .PROC_IRQ_O(p_irq), .PROC_INFO_O(info),
    .PROC_ADDR_O(paddr), .PROC_ACK_I(p_ack), .DIAG_IRQ_O(d_irq), .DIAG_INCOMING_O(d_in),
    .DIAG_CHAN_O(chan), .DIAG_ACK_I(d_ack), .DIAG_LOG_O(dlog), .FAULT_O(fault),
    .REC_ADDR_I(raddr), .REC_DATA_O(rdata));
  tieu_host_model u_host (.clk_i(clk), .rst_n_i(rstn), .hold_i(cfg[6]), .proc_irq_i(p_irq),
    .diag_irq_i(d_irq), .proc_ack_o(p_ack), .diag_ack_o(d_ack));
  task chk(input [31:0] seen, input [31:0] exp, input [39:0] what);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("Error %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle event, then a bounded wait for the request and its ack
  task try(input [36:0] v, input [31:0] exp);
    @(posedge clk) ev <= v;
    @(posedge clk) ev <= 37'h0;
    @(negedge clk);
    for (n = 0; n < 30 && p_irq !== 1'b1; n = n + 1) @(negedge clk);
    chk(info, exp, "info");
    chk(paddr, (exp != 0) ? 32'h1234 : 32'h0, "addr");
    for (n = 0; n < 30 && p_irq === 1'b1 && !cfg[6]; n = n + 1) @(negedge clk);
  endtask
  task wait_diag(input inc);
    for (n = 0; n < 40 && !(d_irq === 1'b1 && d_in === inc); n = n + 1) @(negedge clk);
    chk(d_irq, 1, "diag");
    chk(chan, 3, "chan");
    chk(dlog, 1, "log");
  endtask
  // Record data is registered, so it is read one edge after the address
  task rd(input [1:0] a, input [7:0] exp);
    @(posedge clk) raddr <= a;
    repeat (2) @(negedge clk);
    chk(rdata, exp, "rec");
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(2'h2, 8'h00);
    $display("test reset done");
    try(37'h1, 32'h1);
    try(37'h8000, 32'h8000);
    try(37'h20000, 32'h100000);
    try(37'h80000, 32'h20000);
    try(37'h400000, 32'h40000);
    try(37'h2000000, 32'h40000);
    try(37'h200000000, 32'h8000000);
    @(posedge clk) swg <= 3'h6;
    try(37'h10000, 32'h0);
    @(posedge clk) swg <= 3'h7;
    $display("test counter done");
    @(posedge clk) cfg <= 7'h1e;
    try(37'h800000000, 32'h100000);
    try(37'h1000000000, 32'h1000000);
    @(posedge clk) cfg <= 7'h1f;
    try(37'h1, 32'h0);
    @(posedge clk) cfg <= 7'h15;
    try(37'h1, 32'h0);
    $display("test modes done");
    @(posedge clk) cfg <= 7'h7d;
    try(37'h8, 32'h8);
    try(37'h8, 32'h8);
    wait_diag(1'b1);
    chk(p_irq, 0, "proc");
    chk(fault, 1, "fault");
    rd(2'h0, 8'h0c);
    rd(2'h1, 8'h1f);
    rd(2'h3, 8'h40);
    @(posedge clk) cfg <= 7'h1d;
    mfail <= 1'b1;
    cls <= 1'b0;
    wait_diag(1'b0);
    rd(2'h0, 8'h01);
    rd(2'h1, 8'h05);
    rd(2'h3, 8'h00);
    for (n = 0; n < 40 && fault === 1'b1; n = n + 1) @(negedge clk);
    chk(fault, 0, "fault");
    $display("test diagnostic done");
    @(posedge clk) cfg <= 7'h4d;
    try(37'h4, 32'h4);
    try(37'h4, 32'h4);
    chk(d_irq, 0, "diag");
    rd(2'h0, 8'h09);
    rd(2'h1, 8'h15);
    $display("test disabled done");
    wrap_up;
  end
  // Watchdog against a hung handshake
  initial begin
    #100000;
    fail_count = fail_count + 1;
    wrap_up;
  end
endmodule // tieu_top_bench
bind tieu_top tieu_top_chk u_chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .MODE_I(MODE_I),
  .CNT_OUT_EN_I(CNT_OUT_EN_I), .PROC_ACK_I(PROC_ACK_I), .PROC_IRQ_O(PROC_IRQ_O),
  .PROC_INFO_O(PROC_INFO_O), .DIAG_IRQ_O(DIAG_IRQ_O), .DIAG_INCOMING_O(DIAG_INCOMING_O),
  .DIAG_LOG_O(DIAG_LOG_O), .FAULT_O(FAULT_O), .REC_ADDR_I(REC_ADDR_I),
  .REC_DATA_O(REC_DATA_O));
